/* power_cmd_pkg.sv */
/*
  Constants, command codes, reset values and field positions of the
  power module command bank.
  Assumes two includers, the command bank module and its bench, each importing it whole.
*/
// Functional notes
// [RULE1] Command 0x61 holds rise time, exponent -1, 15 to 500 ms, default 28.
// [RULE2] Command 0x79 reads a summary of all fault and warning conditions.
// [RULE3] Command 0x7a reads output voltage faults and warnings.
// [RULE4] Command 0x7b reads output current faults and warnings.
// [RULE5] Command 0x7c reads input overvoltage and undervoltage faults.
// [RULE6] Command 0x7d reads temperature faults and warnings.
// [RULE7] Command 0x7e reads communication faults.
// [RULE8] Command 0x88 reads measured input voltage word.
// [RULE9] Command 0x8b reads measured output voltage word.
// [RULE10] Command 0x8c reads measured output current word.
// [RULE11] Command 0x8d reads hot-spot temperature word.
// [RULE12] Command 0x98 reads protocol revision 1.2.
// [RULE13] Command 0xe1 is a byte setting secondary pin function, default 0x00.
// [RULE14] Config bit 3 set: enable bit 7 turns output on or off; clear: ignored.
// [RULE15] Config bit 4 set: start needs pin and enable; clear: starts regardless.
// [RULE16] Config bit 2 chooses whether the primary pin must be asserted to start.
// [RULE17] Config bit 1 sets pin polarity; defaults 0x1d negative, 0x1f positive.
// [RULE18] Config bit 0 set: turn-off happens with no delay.
// [RULE19] Overvoltage with response bits 7:6 equal 10 shuts down, then retry field.
// [RULE20] Retry 111 restarts while fault persists (code restarts only once ov_fault clears); 000 never restarts; no delay.
// [RULE21] Invalid or unsupported command code sets communication status bit 7.
// [RULE22] Reserved control bits read as zero and ignore writes.
package power_cmd_pkg;

  localparam logic [7:0] CMD_OUT_ENABLE = 8'h01;
  localparam logic [7:0] CMD_ONOFF_CFG  = 8'h02;
  localparam logic [7:0] CMD_OV_RESP    = 8'h41;
  localparam logic [7:0] CMD_RISE_TIME  = 8'h61;
  localparam logic [7:0] CMD_STAT_SUM   = 8'h79;
  localparam logic [7:0] CMD_STAT_VOUT  = 8'h7a;
  localparam logic [7:0] CMD_STAT_IOUT  = 8'h7b;
  localparam logic [7:0] CMD_STAT_INPUT = 8'h7c;
  localparam logic [7:0] CMD_STAT_TEMP  = 8'h7d;
  localparam logic [7:0] CMD_STAT_COMM  = 8'h7e;
  localparam logic [7:0] CMD_RD_VIN     = 8'h88;
  localparam logic [7:0] CMD_RD_VOUT    = 8'h8b;
  localparam logic [7:0] CMD_RD_IOUT    = 8'h8c;
  localparam logic [7:0] CMD_RD_TEMP    = 8'h8d;
  localparam logic [7:0] CMD_REVISION   = 8'h98;
  localparam logic [7:0] CMD_SEC_PIN    = 8'he1;

  localparam logic [7:0]  OUT_ENABLE_RST = 8'h80;
  localparam logic [7:0]  ONOFF_NEG_RST  = 8'h1d;
  localparam logic [7:0]  ONOFF_POS_RST  = 8'h1f;
  localparam logic [7:0]  OV_RESP_RST    = 8'hb8;
  localparam logic [7:0]  SEC_PIN_RST    = 8'h00;
  localparam logic [7:0]  PROTO_REV      = 8'h22;
  localparam logic [4:0]  RISE_EXP       = 5'h1f;
  localparam logic [10:0] RISE_MANT_RST  = 11'h038;
  localparam logic [10:0] RISE_MANT_MIN  = 11'h01e;
  localparam logic [10:0] RISE_MANT_MAX  = 11'h3e8;

  localparam logic [7:0] OUT_ENABLE_MASK = 8'h80;
  localparam logic [7:0] ONOFF_MASK      = 8'h1f;
  localparam logic [7:0] OV_RESP_MASK    = 8'hf8;

  localparam int OP_EN_BIT    = 7;
  localparam int CFG_MODE_BIT = 4;
  localparam int CFG_CMD_BIT  = 3;
  localparam int CFG_PIN_BIT  = 2;
  localparam int CFG_POL_BIT  = 1;
  localparam int CFG_FAST_BIT = 0;
  localparam int CML_BAD_CMD  = 7;
  localparam int CML_BAD_DATA = 6;

  localparam logic [1:0] OV_ACT_SHUTDOWN = 2'h2;
  localparam logic [2:0] OV_RETRY_ALWAYS = 3'h7;
  localparam logic [2:0] OV_RETRY_NONE   = 3'h0;

  localparam logic [3:0] BYTE_BITS   = 4'h8;
  localparam logic [3:0] LAST_BIT    = 4'h7;
  localparam logic [1:0] CNT_BYTE    = 2'h1;
  localparam logic [1:0] CNT_WORD    = 2'h2;
  localparam logic [1:0] CNT_MAX     = 2'h3;
  localparam logic [7:0] IDLE_BYTE   = 8'hff;

  typedef enum logic [3:0] {
    ST_IDLE     = 4'h0,
    ST_ADDR     = 4'h1,
    ST_ADDR_ACK = 4'h2,
    ST_CMD      = 4'h3,
    ST_CMD_ACK  = 4'h4,
    ST_WR       = 4'h5,
    ST_WR_ACK   = 4'h6,
    ST_RD       = 4'h7,
    ST_RD_ACK   = 4'h8
  } link_state_t;

endpackage

/* power_module_command_set.sv */
/*
  Command register bank of a digitally controlled power module: a bus
  slave on the protocol clock and the command registers, status and
  output on/off control on the controller clock.
  Assumes fault flags and telemetry words come from logic on clk_sys,
  the on/off pin and the bus pins are asynchronous, and the bus clock
  period is well above a few clk_link periods (no clock stretching).
*/
`timescale 1ns/1ps
module power_module_command_set
  import power_cmd_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR       = 7'h40,  // arbitrary default address
  parameter bit         POSITIVE_LOGIC = 1'b0,
  parameter int         OFF_DELAY      = 16
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic        clk_link,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe,
  input  wire logic        on_off_pin,
  input  wire logic        ov_fault,
  input  wire logic        ov_warn,
  input  wire logic        oc_fault,
  input  wire logic        oc_warn,
  input  wire logic        vin_ov_fault,
  input  wire logic        vin_uv_fault,
  input  wire logic        ot_fault,
  input  wire logic        ot_warn,
  input  wire logic        power_good,
  input  wire logic [15:0] vin_meas,
  input  wire logic [15:0] vout_meas,
  input  wire logic [15:0] iout_meas,
  input  wire logic [15:0] temp_meas,
  output logic             output_on,
  output logic [15:0]      rise_time_word,
  output logic [7:0]       secondary_pin_config
);

  localparam logic [7:0] OFF_LAST = 8'(OFF_DELAY - 1);

  // ---------------- protocol clock domain ----------------
  logic        lrst_m_q, lrst_n_q;
  logic        scl_m_q, scl_s_q, scl_p_q, sda_m_q, sda_s_q, sda_p_q;
  link_state_t st_q;
  logic [3:0]  bit_cnt_q;
  logic [7:0]  shreg_q, tx_q, cmd_q;
  logic [15:0] wdata_q, rd_link_q;
  logic [1:0]  wcnt_q;
  logic        rw_q, byte_idx_q, nack_q;
  logic        cmd_tog_q, wr_tog_q, sda_oe_q, sda_o_q;
  logic        ack_m_q, ack_s_q, ack_p_q;
  // both written on clk_sys; the word is taken here only on an ack toggle
  logic [15:0] rd_word_q;
  logic        ack_tog_q;

  always_ff @(posedge clk_link or negedge rstn) begin
    if (!rstn) begin
      lrst_m_q <= 1'b0;
      lrst_n_q <= 1'b0;
    end else begin
      lrst_m_q <= 1'b1;
      lrst_n_q <= lrst_m_q;
    end
  end

  always_ff @(posedge clk_link or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      {scl_m_q, scl_s_q, scl_p_q} <= 3'h7;
      {sda_m_q, sda_s_q, sda_p_q} <= 3'h7;
      {ack_m_q, ack_s_q, ack_p_q} <= 3'h0;
    end else begin
      {scl_m_q, scl_s_q, scl_p_q} <= {scl_i, scl_m_q, scl_s_q};
      {sda_m_q, sda_s_q, sda_p_q} <= {sda_i, sda_m_q, sda_s_q};
      {ack_m_q, ack_s_q, ack_p_q} <= {ack_tog_q, ack_m_q, ack_s_q};
    end
  end

  logic scl_rise, scl_fall, start_cond, stop_cond;
  assign scl_rise   = scl_s_q & ~scl_p_q;
  assign scl_fall   = ~scl_s_q & scl_p_q;
  assign start_cond = scl_s_q & scl_p_q & sda_p_q & ~sda_s_q;
  assign stop_cond  = scl_s_q & scl_p_q & ~sda_p_q & sda_s_q;

  // read word arrives from the controller domain after each command byte
  always_ff @(posedge clk_link or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      rd_link_q <= 16'h0000;
    end else if (ack_s_q ^ ack_p_q) begin
      rd_link_q <= rd_word_q;
    end
  end

  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic idx);
    pick_byte = idx ? w[15:8] : w[7:0];
  endfunction

  always_ff @(posedge clk_link or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      st_q       <= ST_IDLE;
      bit_cnt_q  <= 4'h0;
      shreg_q    <= 8'h00;
      tx_q       <= 8'h00;
      cmd_q      <= 8'h00;
      wdata_q    <= 16'h0000;
      wcnt_q     <= 2'h0;
      rw_q       <= 1'b0;
      byte_idx_q <= 1'b0;
      nack_q     <= 1'b0;
      cmd_tog_q  <= 1'b0;
      wr_tog_q   <= 1'b0;
      sda_oe_q   <= 1'b0;
    end else if (start_cond) begin
      st_q      <= ST_ADDR;
      bit_cnt_q <= 4'h0;
      sda_oe_q  <= 1'b0;
      wcnt_q    <= 2'h0;
    end else if (stop_cond) begin
      // count held past stop: the controller side reads it after the toggle
      st_q     <= ST_IDLE;
      sda_oe_q <= 1'b0;
      if (wcnt_q != 2'h0) begin
        wr_tog_q <= ~wr_tog_q;
      end
    end else begin
      case (st_q)
        ST_ADDR, ST_CMD, ST_WR: begin
          if (scl_rise) begin
            shreg_q   <= {shreg_q[6:0], sda_s_q};
            bit_cnt_q <= bit_cnt_q + 4'h1;
          end else if (scl_fall && bit_cnt_q == BYTE_BITS) begin
            bit_cnt_q <= 4'h0;
            sda_oe_q  <= 1'b1;
            if (st_q == ST_ADDR) begin
              if (shreg_q[7:1] == DEV_ADDR) begin
                rw_q <= shreg_q[0];
                st_q <= ST_ADDR_ACK;
              end else begin
                sda_oe_q <= 1'b0;
                st_q     <= ST_IDLE;
              end
            end else if (st_q == ST_CMD) begin
              cmd_q     <= shreg_q;
              cmd_tog_q <= ~cmd_tog_q;
              wcnt_q    <= 2'h0;
              st_q      <= ST_CMD_ACK;
            end else begin
              if (wcnt_q == 2'h0) begin
                wdata_q[7:0] <= shreg_q;
              end else if (wcnt_q == CNT_BYTE) begin
                wdata_q[15:8] <= shreg_q;
              end
              if (wcnt_q != CNT_MAX) begin
                wcnt_q <= wcnt_q + 2'h1;
              end
              st_q <= ST_WR_ACK;
            end
          end
        end
        ST_ADDR_ACK: begin
          if (scl_fall) begin
            if (rw_q) begin
              tx_q       <= pick_byte(rd_link_q, 1'b0);
              sda_oe_q   <= ~rd_link_q[7];
              byte_idx_q <= 1'b0;
              st_q       <= ST_RD;
            end else begin
              sda_oe_q <= 1'b0;
              st_q     <= ST_CMD;
            end
          end
        end
        ST_CMD_ACK, ST_WR_ACK: begin
          if (scl_fall) begin
            sda_oe_q <= 1'b0;
            st_q     <= ST_WR;
          end
        end
        ST_RD: begin
          if (scl_fall) begin
            if (bit_cnt_q == LAST_BIT) begin
              sda_oe_q  <= 1'b0;
              bit_cnt_q <= 4'h0;
              st_q      <= ST_RD_ACK;
            end else begin
              tx_q      <= {tx_q[6:0], 1'b0};
              sda_oe_q  <= ~tx_q[6];
              bit_cnt_q <= bit_cnt_q + 4'h1;
            end
          end
        end
        ST_RD_ACK: begin
          if (scl_rise) begin
            nack_q <= sda_s_q;
          end else if (scl_fall) begin
            if (nack_q) begin
              st_q <= ST_IDLE;
            end else begin
              tx_q       <= byte_idx_q ? IDLE_BYTE : pick_byte(rd_link_q, 1'b1);
              sda_oe_q   <= byte_idx_q ? 1'b0 : ~rd_link_q[15];
              byte_idx_q <= 1'b1;
              st_q       <= ST_RD;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_link or negedge lrst_n_q) begin
    if (!lrst_n_q) begin
      sda_o_q <= 1'b0;
    end else begin
      sda_o_q <= 1'b0;
    end
  end

  assign sda_o  = sda_o_q;
  assign sda_oe = sda_oe_q;

  // ---------------- controller clock domain ----------------
  logic [7:0]  op_q, onoff_q, ovresp_q, sec_q, cml_q;
  logic [15:0] rise_q;
  logic [2:0]  ct_q, wt_q;
  logic        pin_m_q, pin_s_q;
  logic [9:0]  stat_q;
  logic        ov_off_q, on_q;
  logic [7:0]  off_cnt_q;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ct_q    <= 3'h0;
      wt_q    <= 3'h0;
      pin_m_q <= 1'b0;
      pin_s_q <= 1'b0;
      stat_q  <= 10'h000;
    end else begin
      ct_q    <= {ct_q[1:0], cmd_tog_q};
      wt_q    <= {wt_q[1:0], wr_tog_q};
      pin_m_q <= on_off_pin;
      pin_s_q <= pin_m_q;
      stat_q  <= {ov_fault, ov_warn, oc_fault, oc_warn, vin_ov_fault, vin_uv_fault,
                  ot_fault, ot_warn, ~power_good, 1'b0};
    end
  end

  logic cmd_evt, wr_evt;
  assign cmd_evt = ct_q[2] ^ ct_q[1];
  assign wr_evt  = wt_q[2] ^ wt_q[1];

  logic [7:0]  st_vout, st_iout, st_input, st_temp;
  logic [15:0] st_sum;
  assign st_vout  = {stat_q[9], stat_q[8], 6'h00};                          // RULE3
  assign st_iout  = {stat_q[7], 1'b0, stat_q[6], 5'h00};                    // RULE4
  assign st_input = {stat_q[5], 2'h0, stat_q[4], 4'h0};                     // RULE5
  assign st_temp  = {stat_q[3], stat_q[2], 6'h00};                          // RULE6
  assign st_sum   = {|st_vout, |st_iout, |st_input, 1'b0, stat_q[1], 3'h0,  // RULE2
                     1'b0, ~on_q, stat_q[9], stat_q[7], stat_q[4], |st_temp,
                     |cml_q, 1'b0};

  logic [15:0] rd_val;
  logic        rd_ok;
  always_comb begin
    rd_ok  = 1'b1;
    rd_val = 16'h0000;
    if (cmd_q == CMD_OUT_ENABLE) rd_val = {8'h00, op_q};
    else if (cmd_q == CMD_ONOFF_CFG) rd_val = {8'h00, onoff_q};
    else if (cmd_q == CMD_OV_RESP) rd_val = {8'h00, ovresp_q};
    else if (cmd_q == CMD_RISE_TIME) rd_val = rise_q;              // RULE1
    else if (cmd_q == CMD_STAT_SUM) rd_val = st_sum;               // RULE2
    else if (cmd_q == CMD_STAT_VOUT) rd_val = {8'h00, st_vout};    // RULE3
    else if (cmd_q == CMD_STAT_IOUT) rd_val = {8'h00, st_iout};    // RULE4
    else if (cmd_q == CMD_STAT_INPUT) rd_val = {8'h00, st_input};  // RULE5
    else if (cmd_q == CMD_STAT_TEMP) rd_val = {8'h00, st_temp};    // RULE6
    else if (cmd_q == CMD_STAT_COMM) rd_val = {8'h00, cml_q};      // RULE7
    else if (cmd_q == CMD_RD_VIN) rd_val = vin_meas;               // RULE8
    else if (cmd_q == CMD_RD_VOUT) rd_val = vout_meas;             // RULE9
    else if (cmd_q == CMD_RD_IOUT) rd_val = iout_meas;             // RULE10
    else if (cmd_q == CMD_RD_TEMP) rd_val = temp_meas;             // RULE11
    else if (cmd_q == CMD_REVISION) rd_val = {8'h00, PROTO_REV};   // RULE12
    else if (cmd_q == CMD_SEC_PIN) rd_val = {8'h00, sec_q};        // RULE13
    else rd_ok = 1'b0;
  end

  function automatic logic rise_valid(input logic [15:0] w);
    rise_valid = (w[15:11] == RISE_EXP) && (w[10:0] >= RISE_MANT_MIN) &&
                 (w[10:0] <= RISE_MANT_MAX);
  endfunction

  // command lookup and read answer back to the protocol domain
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rd_word_q <= 16'h0000;
      ack_tog_q <= 1'b0;
    end else if (cmd_evt) begin
      rd_word_q <= rd_val;
      ack_tog_q <= ~ack_tog_q;
    end
  end

  // writable commands; reserved bits are masked off on write
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      op_q     <= OUT_ENABLE_RST;                                  // RULE14
      onoff_q  <= POSITIVE_LOGIC ? ONOFF_POS_RST : ONOFF_NEG_RST;  // RULE17
      ovresp_q <= OV_RESP_RST;                                     // RULE19
      rise_q   <= {RISE_EXP, RISE_MANT_RST};                       // RULE1
      sec_q    <= SEC_PIN_RST;                                     // RULE13
    end else if (wr_evt && wcnt_q == CNT_BYTE) begin
      if (cmd_q == CMD_OUT_ENABLE) begin
        op_q <= wdata_q[7:0] & OUT_ENABLE_MASK;                    // RULE22
      end else if (cmd_q == CMD_ONOFF_CFG) begin
        onoff_q <= wdata_q[7:0] & ONOFF_MASK;                      // RULE22
      end else if (cmd_q == CMD_OV_RESP) begin
        ovresp_q <= wdata_q[7:0] & OV_RESP_MASK;                   // RULE20
      end else if (cmd_q == CMD_SEC_PIN) begin
        sec_q <= wdata_q[7:0];                                     // RULE13
      end
    end else if (wr_evt && wcnt_q == CNT_WORD && cmd_q == CMD_RISE_TIME) begin
      if (rise_valid(wdata_q)) begin
        rise_q <= wdata_q;                                         // RULE1
      end
    end
  end

  logic wr_bad_cmd, wr_bad_data, byte_cmd;
  assign byte_cmd    = (cmd_q == CMD_OUT_ENABLE) || (cmd_q == CMD_ONOFF_CFG) ||
                       (cmd_q == CMD_OV_RESP) || (cmd_q == CMD_SEC_PIN);
  assign wr_bad_cmd  = !byte_cmd && (cmd_q != CMD_RISE_TIME);
  assign wr_bad_data = byte_cmd ? (wcnt_q != CNT_BYTE) :
                       ((wcnt_q != CNT_WORD) || !rise_valid(wdata_q));

  // sticky communication faults, cleared only by reset
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cml_q <= 8'h00;
    end else begin
      if ((cmd_evt && !rd_ok) || (wr_evt && wr_bad_cmd)) begin
        cml_q[CML_BAD_CMD] <= 1'b1;                                // RULE21
      end
      if (wr_evt && !wr_bad_cmd && wr_bad_data) begin
        cml_q[CML_BAD_DATA] <= 1'b1;
      end
    end
  end

  // on/off decision
  logic pin_act, run_req, ov_hit, want_on, retry_all;
  assign pin_act   = onoff_q[CFG_POL_BIT] ? pin_s_q : ~pin_s_q;        // RULE17
  assign run_req   = !onoff_q[CFG_MODE_BIT] ||                         // RULE15
                     ((!onoff_q[CFG_PIN_BIT] || pin_act) &&            // RULE16
                      (!onoff_q[CFG_CMD_BIT] || op_q[OP_EN_BIT]));     // RULE14
  assign ov_hit    = ov_fault && (ovresp_q[7:6] == OV_ACT_SHUTDOWN);  // RULE19
  assign retry_all = ovresp_q[5:3] == OV_RETRY_ALWAYS;
  assign want_on   = run_req && !ov_off_q && !ov_hit;

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ov_off_q <= 1'b0;
    end else if (ov_hit) begin
      ov_off_q <= 1'b1;                                                // RULE19
    end else if (retry_all || !run_req) begin
      ov_off_q <= 1'b0;                                                // RULE20
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      on_q      <= 1'b0;
      off_cnt_q <= 8'h00;
    end else if (want_on) begin
      on_q      <= 1'b1;
      off_cnt_q <= 8'h00;
    end else if (on_q) begin
      if (onoff_q[CFG_FAST_BIT] || ov_hit || off_cnt_q >= OFF_LAST) begin
        on_q <= 1'b0;                                                  // RULE18
      end else begin
        off_cnt_q <= off_cnt_q + 8'h01;
      end
    end
  end

  assign output_on            = on_q;
  assign rise_time_word       = rise_q;
  assign secondary_pin_config = sec_q;

  // ---------------- checks ----------------
  sequence s_bad_cmd;
    cmd_evt && !rd_ok;
  endsequence
  sequence s_ov_latched;
    ov_off_q && ovresp_q[5:3] == OV_RETRY_NONE && run_req && !ov_hit;
  endsequence

  property p_rise_range;
    @(posedge clk_sys) disable iff (!rstn) rise_valid(rise_q);
  endproperty
  a_rise_range: assert property (p_rise_range) else $error("rise time out of range"); // RULE1

  property p_revision;
    @(posedge clk_sys) disable iff (!rstn)
      cmd_evt && cmd_q == CMD_REVISION |=> rd_word_q[7:0] == PROTO_REV;
  endproperty
  a_revision: assert property (p_revision) else $error("wrong revision answer"); // RULE12

  property p_cmd_off;
    @(posedge clk_sys) disable iff (!rstn)
      onoff_q[CFG_MODE_BIT] && onoff_q[CFG_CMD_BIT] && onoff_q[CFG_FAST_BIT] &&
      !op_q[OP_EN_BIT] |=> !on_q;
  endproperty
  a_cmd_off: assert property (p_cmd_off) else $error("output on against enable"); // RULE14

  property p_force_on;
    @(posedge clk_sys) disable iff (!rstn)
      !onoff_q[CFG_MODE_BIT] && !ov_off_q && !ov_hit |=> on_q;
  endproperty
  a_force_on: assert property (p_force_on) else $error("output not on"); // RULE15

  property p_pin_gate;
    @(posedge clk_sys) disable iff (!rstn)
      onoff_q[CFG_MODE_BIT] && onoff_q[CFG_PIN_BIT] && onoff_q[CFG_FAST_BIT] &&
      !pin_act |=> !on_q;
  endproperty
  a_pin_gate: assert property (p_pin_gate) else $error("pin did not gate output"); // RULE16

  property p_slow_off;
    @(posedge clk_sys) disable iff (!rstn)
      on_q && !want_on && !onoff_q[CFG_FAST_BIT] && !ov_hit && off_cnt_q == 8'h00
      |=> on_q;
  endproperty
  a_slow_off: assert property (p_slow_off) else $error("delayed off was immediate"); // RULE18

  property p_ov_shutdown;
    @(posedge clk_sys) disable iff (!rstn) ov_hit |=> !on_q ##1 (ov_off_q || retry_all);
  endproperty
  a_ov_shutdown: assert property (p_ov_shutdown) else $error("no overvoltage shutdown"); // RULE19

  property p_no_retry;
    @(posedge clk_sys) disable iff (!rstn) s_ov_latched |=> ov_off_q && !on_q;
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("restarted without retry"); // RULE20

  property p_bad_cmd;
    @(posedge clk_sys) disable iff (!rstn) s_bad_cmd |=> cml_q[CML_BAD_CMD];
  endproperty
  a_bad_cmd: assert property (p_bad_cmd) else $error("bad command not flagged"); // RULE21

  property p_reserved;
    @(posedge clk_sys) disable iff (!rstn)
      op_q[6:0] == 7'h00 && onoff_q[7:5] == 3'h0 && ovresp_q[2:0] == 3'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set"); // RULE22

endmodule

/* pmbus_host_model.sv */
/* bus host model: bit-banged master, one call per transfer.
   assumes the bench resolves the open-drain data line with a pull-up. */
`timescale 1ns/1ps
module pmbus_host_model #(
  parameter logic [6:0] ADDR = 7'h40
) (
  output logic      scl,
  output logic      pull_low,
  input  wire logic sda
);
  logic acks_ok;
  initial begin
    scl = 1'b1;
    pull_low = 1'b0;
    acks_ok = 1'b1;
  end
  // data moves only while scl is low, held across the high phase
  task automatic bit_io(input logic b, output logic r);
    pull_low = !b;
    #256 scl = 1'b1;
    #256 r = sda;
    #256 scl = 1'b0;
    #256;
  endtask
  task automatic byte_io(input logic [7:0] d, input logic a, input logic chk,
                         output logic [7:0] q);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(d[i], q[i]);
    bit_io(a, r);
    if (chk) acks_ok &= (r === 1'b0);
  endtask
  task automatic xfer(input logic [7:0] cmd, input int nw, input logic [15:0] wd,
                      input int nr, output logic [15:0] rd);
    logic [7:0] q;
    rd = 16'h0000;
    pull_low = 1'b1;
    #256 scl = 1'b0;
    #256 byte_io({ADDR, 1'b0}, 1'b1, 1'b1, q);
    byte_io(cmd, 1'b1, 1'b1, q);
    for (int i = 0; i < nw; i++) byte_io(wd[8*i +: 8], 1'b1, 1'b1, q);
    if (nr > 0) begin
      pull_low = 1'b0;
      #256 scl = 1'b1;
      #256 pull_low = 1'b1;
      #256 scl = 1'b0;
      #256 byte_io({ADDR, 1'b1}, 1'b1, 1'b1, q);
      for (int i = 0; i < nr; i++) begin
        byte_io(8'hff, i == nr - 1, 1'b0, q);
        rd[8*i +: 8] = q;
      end
    end
    pull_low = 1'b1;
    #256 scl = 1'b1;
    #256 pull_low = 1'b0;
    #512;
  endtask
endmodule

/* power_module_command_set_tb.sv */
/* bench for the command bank: host model on the bus, levels on pins.
   assumes a pull-up on the data line and free-running clocks. */
`timescale 1ns/1ps
module power_module_command_set_tb;
  import power_cmd_pkg::*;
  logic        clk_sys = 1'b0, clk_link = 1'b0, rstn = 1'b0, pin = 1'b0, pg = 1'b1;
  logic [7:0]  flt = 8'h00;
  logic [15:0] meas [4] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic        scl, pull_low, sda_o, sda_oe, output_on;
  logic [15:0] rise_w, rd;
  logic [7:0]  sec;
  int          fail_count = 0, total_checks = 0;
  wire         sda = !(pull_low || (sda_oe && !sda_o));
  always #10 clk_sys = !clk_sys;
  initial #7 forever #32 clk_link = !clk_link;
  pmbus_host_model u_host (.scl(scl), .pull_low(pull_low), .sda(sda));
  power_module_command_set #(.OFF_DELAY(2)) u_dut (
    .clk_sys(clk_sys), .rstn(rstn), .clk_link(clk_link), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_o), .sda_oe(sda_oe), .on_off_pin(pin), .ov_fault(flt[7]),
    .ov_warn(flt[6]), .oc_fault(flt[5]), .oc_warn(flt[4]), .vin_ov_fault(flt[3]),
    .vin_uv_fault(flt[2]), .ot_fault(flt[1]), .ot_warn(flt[0]), .power_good(pg),
    .vin_meas(meas[0]), .vout_meas(meas[1]), .iout_meas(meas[2]),
    .temp_meas(meas[3]), .output_on(output_on), .rise_time_word(rise_w),
    .secondary_pin_config(sec));
  task automatic summarize();
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rw(input logic [7:0] c, input int nw, input logic [15:0] w, input int nr);
    u_host.xfer(c, nw, w, nr, rd);
    chk("ack", 16'h0001, {15'h0000, u_host.acks_ok});
  endtask
  task automatic on(input logic e);
    for (int i = 0; i < 400 && output_on !== e; i++) @(negedge clk_sys);
    chk("output_on", {15'h0000, e}, {15'h0000, output_on});
    if (output_on !== e) summarize();
  endtask
  task automatic t_reset();
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    repeat (8) @(posedge clk_link);
    chk("rise", 16'hf838, rise_w);
    chk("sec", 16'h0000, {8'h00, sec});
    on(1'b1);
    @(posedge clk_sys) pin <= 1'b1;
    on(1'b0);
    @(posedge clk_sys) pin <= 1'b0;
    on(1'b1);
  endtask
  task automatic t_enable();
    rw(8'h01, 1, 16'h0000, 0);
    on(1'b0);
    rw(8'h01, 1, 16'h00ff, 0);
    rw(8'h01, 0, 16'h0000, 1);
    chk("enable", 16'h0080, rd);
    on(1'b1);
    rw(8'h02, 1, 16'h00ff, 0);
    rw(8'h02, 0, 16'h0000, 1);
    chk("config", 16'h001f, rd);
    on(1'b0);
    rw(8'h02, 1, 16'h0000, 0);
    on(1'b1);
    rw(8'h02, 1, 16'h001c, 0);
    rw(8'h01, 1, 16'h0000, 0);
    on(1'b0);
    rw(8'h01, 1, 16'h0080, 0);
    rw(8'h02, 1, 16'h001d, 0);
    on(1'b1);
    rw(8'he1, 1, 16'h00a5, 0);
    rw(8'he1, 0, 16'h0000, 1);
    chk("sec_pin", 16'h00a5, {8'h00, sec});
    chk("sec", 16'h00a5, rd);
  endtask
  task automatic t_read();
    logic [7:0] st [4] = '{8'hc0, 8'ha0, 8'h90, 8'hc0};
    rw(8'h61, 2, 16'hf8c8, 0);
    chk("rise", 16'hf8c8, rise_w);
    rw(8'h61, 2, 16'hf80a, 0);
    rw(8'h61, 0, 16'h0000, 2);
    chk("rise", 16'hf8c8, rd);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys) meas[i] <= 16'h1234 + 16'(i * 16'h1111);
      rw(8'h88 + 8'(i == 0 ? 0 : i + 2), 0, 16'h0000, 2);
      chk("reading", 16'h1234 + 16'(i * 16'h1111), rd);
    end
    rw(8'h98, 0, 16'h0000, 1);
    chk("revision", 16'h0022, rd);
    @(posedge clk_sys);
    flt <= 8'hff;
    pg  <= 1'b0;
    on(1'b0);
    for (int i = 0; i < 4; i++) begin
      rw(8'h7a + 8'(i), 0, 16'h0000, 1);
      chk("status", {8'h00, st[i]}, rd);
    end
    rw(8'h79, 0, 16'h0000, 2);
    chk("summary", 16'he87e, rd);
    @(posedge clk_sys);
    flt <= 8'h00;
    pg  <= 1'b1;
    on(1'b1);
    rw(8'h50, 0, 16'h0000, 1);
    chk("unknown", 16'h0000, rd);
    rw(8'h7e, 0, 16'h0000, 1);
    chk("comm", 16'h00c0, rd);
  endtask
  task automatic t_ov();
    rw(8'h41, 1, 16'h00ff, 0);
    rw(8'h41, 0, 16'h0000, 1);
    chk("ov_resp", 16'h00f8, rd);
    rw(8'h41, 1, 16'h0080, 0);
    @(posedge clk_sys) flt <= 8'h80;
    on(1'b0);
    @(posedge clk_sys) flt <= 8'h00;
    repeat (40) @(negedge clk_sys);
    chk("output_on", 16'h0000, {15'h0000, output_on});
    rw(8'h01, 1, 16'h0000, 0);
    rw(8'h01, 1, 16'h0080, 0);
    on(1'b1);
  endtask
  initial begin
    t_reset();
    t_enable();
    t_read();
    t_ov();
    summarize();
  end
  initial begin
    #1900000;
    fail_count++;
    summarize();
  end
endmodule
